// File: rtl/sensor_user_config_register.sv
// two-wire serial slave giving access to the user configuration register
`timescale 1ns/1ps
`default_nettype none
`include "ucfg_params.svh"
module sensor_user_config_register #(
    // bus address of this slave; default value is arbitrary
    parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // serial bus, data is open drain
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // supply monitor comparator
    input wire logic SUPPLY_LOW_IN,
    // decoded configuration
    output logic HEATER_ENABLE,
    output logic [1:0] RESOLUTION_CODE,
    output logic [4:0] HUMIDITY_BITS,
    output logic [4:0] TEMPERATURE_BITS
);
    ucfg_link_if link ();

    // two-flop synchronisers, plus one history stage on scl and sda for edge detect
    logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
    logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
    logic sup_meta_reg, sup_sync_reg;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            sup_meta_reg <= 1'b0;
            sup_sync_reg <= 1'b0;
        end else begin
            scl_meta_reg <= SCL_IN;
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= SDA_IN;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
            sup_meta_reg <= SUPPLY_LOW_IN;
            sup_sync_reg <= sup_meta_reg;
        end
    end

    // bus events seen only on synchronised copies
    logic scl_rise, scl_fall, start_cond, stop_cond;
    assign scl_rise = scl_sync_reg & ~scl_prev_reg;
    assign scl_fall = ~scl_sync_reg & scl_prev_reg;
    assign start_cond = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
    assign stop_cond = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

    ucfg_pkg::serial_state_t state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] tx_reg, tx_next;
    logic rd_pending_reg, rd_pending_next;
    logic oe_reg, oe_next;
    logic wr_en_reg, wr_en_next;
    logic [7:0] wr_data_reg, wr_data_next;
    logic byte_done;

    assign byte_done = (cnt_reg == `UCFG_BYTE_BITS);

    // protocol sequencing; sample on scl rise, change data on scl fall
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        rd_pending_next = rd_pending_reg;
        oe_next = oe_reg;
        wr_en_next = 1'b0;
        wr_data_next = wr_data_reg;
        if (stop_cond) begin
            state_next = ucfg_pkg::ST_IDLE;
            rd_pending_next = 1'b0;
            oe_next = 1'b0;
        end else if (start_cond) begin
            // repeated start keeps a pending read command
            state_next = ucfg_pkg::ST_ADDR;
            cnt_next = 4'h0;
            oe_next = 1'b0;
        end else begin
            if (scl_rise && !byte_done) begin
                shift_next = {shift_reg[6:0], sda_sync_reg};
                cnt_next = cnt_reg + 4'h1;
            end
            case (state_reg)
                ucfg_pkg::ST_ADDR: begin
                    if (scl_fall && byte_done) begin
                        cnt_next = 4'h0;
                        if (shift_reg[7:1] != SLAVE_ADDR) begin
                            state_next = ucfg_pkg::ST_IGNORE;
                        end else if (!shift_reg[0]) begin
                            state_next = ucfg_pkg::ST_ADDR_ACK;
                            rd_pending_next = 1'b0;
                            oe_next = 1'b1;
                        end else if (rd_pending_reg) begin
                            state_next = ucfg_pkg::ST_ADDR_ACK;
                            oe_next = 1'b1;
                        end else begin
                            // read without a register command: not ours, no ack
                            state_next = ucfg_pkg::ST_IGNORE;
                        end
                    end
                end
                ucfg_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_next = 4'h0;
                        if (rd_pending_reg) begin
                            state_next = ucfg_pkg::ST_RDATA;
                            tx_next = link.rd_data;
                            oe_next = ~link.rd_data[7];
                        end else begin
                            state_next = ucfg_pkg::ST_CMD;
                            oe_next = 1'b0;
                        end
                    end
                end
                ucfg_pkg::ST_CMD: begin
                    if (scl_fall && byte_done) begin
                        cnt_next = 4'h0;
                        if (shift_reg == `UCFG_CMD_WRITE) begin
                            state_next = ucfg_pkg::ST_CMD_ACK;
                            oe_next = 1'b1;
                        end else if (shift_reg == `UCFG_CMD_READ) begin
                            state_next = ucfg_pkg::ST_CMD_ACK;
                            rd_pending_next = 1'b1;
                            oe_next = 1'b1;
                        end else begin
                            // other locations are reserved and not acknowledged
                            state_next = ucfg_pkg::ST_IGNORE;
                        end
                    end
                end
                ucfg_pkg::ST_CMD_ACK: begin
                    if (scl_fall) begin
                        cnt_next = 4'h0;
                        oe_next = 1'b0;
                        state_next = rd_pending_reg ? ucfg_pkg::ST_IGNORE
                                                    : ucfg_pkg::ST_WDATA;
                    end
                end
                ucfg_pkg::ST_WDATA: begin
                    if (scl_fall && byte_done) begin
                        cnt_next = 4'h0;
                        wr_en_next = 1'b1;
                        wr_data_next = shift_reg;
                        state_next = ucfg_pkg::ST_WDATA_ACK;
                        oe_next = 1'b1;
                    end
                end
                ucfg_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        // extra bytes after the single data byte get no ack
                        oe_next = 1'b0;
                        state_next = ucfg_pkg::ST_IGNORE;
                    end
                end
                ucfg_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (byte_done) begin
                            cnt_next = 4'h0;
                            oe_next = 1'b0;
                            state_next = ucfg_pkg::ST_RDATA_ACK;
                        end else begin
                            tx_next = {tx_reg[6:0], 1'b1};
                            oe_next = ~tx_reg[6];
                        end
                    end
                end
                ucfg_pkg::ST_RDATA_ACK: begin
                    // no checksum whether host acks or not
                    if (scl_fall) begin
                        state_next = ucfg_pkg::ST_IGNORE;
                        rd_pending_next = 1'b0;
                        oe_next = 1'b0;
                    end
                end
                ucfg_pkg::ST_IDLE, ucfg_pkg::ST_IGNORE: begin
                    oe_next = 1'b0;
                end
                default: begin
                    state_next = ucfg_pkg::ST_IDLE;
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state_reg <= ucfg_pkg::ST_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'hff;
            rd_pending_reg <= 1'b0;
            oe_reg <= 1'b0;
            wr_en_reg <= 1'b0;
            wr_data_reg <= `UCFG_RESET_VALUE;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            rd_pending_reg <= rd_pending_next;
            oe_reg <= oe_next;
            wr_en_reg <= wr_en_next;
            wr_data_reg <= wr_data_next;
        end
    end

    assign link.wr_en = wr_en_reg;
    assign link.wr_data = wr_data_reg;
    assign link.supply_low = sup_sync_reg;

    // open drain: only ever pull low
    assign SDA_OUT = 1'b0;
    assign SDA_OE = oe_reg;

    user_config_bank bank (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .link(link.bank),
        .heater_enable(HEATER_ENABLE),
        .resolution_code(RESOLUTION_CODE),
        .humidity_bits(HUMIDITY_BITS),
        .temperature_bits(TEMPERATURE_BITS)
    );
endmodule
`default_nettype wire

// File: rtl/ucfg_link_if.sv
// link between the serial front end and the register bank
`timescale 1ns/1ps
`default_nettype none
interface ucfg_link_if;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic supply_low;

    modport bank (input wr_en, input wr_data, input supply_low, output rd_data);
    modport access (output wr_en, output wr_data, output supply_low, input rd_data);
endinterface
`default_nettype wire

// File: rtl/ucfg_params.svh
// constants for the sensor user configuration register and its serial access
`ifndef UCFG_PARAMS_SVH
`define UCFG_PARAMS_SVH

// command bytes
`define UCFG_CMD_WRITE 8'he6
`define UCFG_CMD_READ 8'he7

// field positions in the user register
`define UCFG_POS_RES_HIGH 7
`define UCFG_POS_SUPPLY 6
`define UCFG_POS_HEATER 2
`define UCFG_POS_RES_LOW 0

// reserved bits 5,4,3,1 and their forced value
`define UCFG_RESERVED_MASK 8'h3a
`define UCFG_RESET_VALUE 8'h3a

// serial framing: bits per byte
`define UCFG_BYTE_BITS 4'h8

// conversion widths per resolution code
`define UCFG_RH_BITS_00 5'h0c
`define UCFG_RH_BITS_01 5'h08
`define UCFG_RH_BITS_10 5'h0a
`define UCFG_RH_BITS_11 5'h0b
`define UCFG_T_BITS_00 5'h0e
`define UCFG_T_BITS_01 5'h0c
`define UCFG_T_BITS_10 5'h0d
`define UCFG_T_BITS_11 5'h0b

`endif

// File: rtl/ucfg_pkg.sv
// types and helpers shared by the user configuration files
`default_nettype none
`include "ucfg_params.svh"
package ucfg_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_IGNORE
    } serial_state_t;

    typedef struct packed {
        logic [4:0] humidity_bits;
        logic [4:0] temperature_bits;
    } resolution_t;

    // resolution code to conversion widths
    function automatic resolution_t decode_resolution(input logic [1:0] code);
        resolution_t r;
        case (code)
            2'h0: begin
                r.humidity_bits = `UCFG_RH_BITS_00;
                r.temperature_bits = `UCFG_T_BITS_00;
            end
            2'h1: begin
                r.humidity_bits = `UCFG_RH_BITS_01;
                r.temperature_bits = `UCFG_T_BITS_01;
            end
            2'h2: begin
                r.humidity_bits = `UCFG_RH_BITS_10;
                r.temperature_bits = `UCFG_T_BITS_10;
            end
            default: begin
                r.humidity_bits = `UCFG_RH_BITS_11;
                r.temperature_bits = `UCFG_T_BITS_11;
            end
        endcase
        return r;
    endfunction
endpackage
`default_nettype wire

// File: rtl/user_config_bank.sv
// user configuration register storage and its decoded outputs
`timescale 1ns/1ps
`default_nettype none
`include "ucfg_params.svh"
module user_config_bank (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // front end side
    ucfg_link_if.bank link,
    // decoded controls
    output logic heater_enable,
    output logic [1:0] resolution_code,
    output logic [4:0] humidity_bits,
    output logic [4:0] temperature_bits
);
    logic [7:0] value_reg, value_next;
    logic [4:0] rh_reg, rh_next, t_reg, t_next;
    ucfg_pkg::resolution_t res;

    // writable bits only; reserved stay forced, stored supply bit cleared to zero
    always_comb begin
        value_next = value_reg;
        if (link.wr_en) begin
            value_next = link.wr_data | `UCFG_RESERVED_MASK;
            value_next[`UCFG_POS_SUPPLY] = 1'b0;
        end
        res = ucfg_pkg::decode_resolution(
            {value_next[`UCFG_POS_RES_HIGH], value_next[`UCFG_POS_RES_LOW]});
        rh_next = res.humidity_bits;
        t_next = res.temperature_bits;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            value_reg <= `UCFG_RESET_VALUE;
            rh_reg <= `UCFG_RH_BITS_00;
            t_reg <= `UCFG_T_BITS_00;
        end else begin
            value_reg <= value_next;
            rh_reg <= rh_next;
            t_reg <= t_next;
        end
    end

    // read view merges live supply flag
    always_comb begin
        link.rd_data = value_reg | `UCFG_RESERVED_MASK;
        link.rd_data[`UCFG_POS_SUPPLY] = link.supply_low;
    end

    assign heater_enable = value_reg[`UCFG_POS_HEATER];
    assign resolution_code = {value_reg[`UCFG_POS_RES_HIGH], value_reg[`UCFG_POS_RES_LOW]};
    assign humidity_bits = rh_reg;
    assign temperature_bits = t_reg;
endmodule
`default_nettype wire

// File: verif/i2c_host_model.sv
// behavioural two-wire host for the configuration slave
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    // clock
    input wire logic clk,
    // bus lines, sda released while sda_rel is high
    output logic scl,
    output logic sda_rel,
    input wire logic sda_line
);
    int half = 6; // clocks per scl phase, raised for a slow host
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic hold();
        repeat (half) @(negedge clk);
    endtask
    // one bit; sda moves 4 clocks after scl fall, never while scl is high
    task automatic bit_io(input logic b, output logic r);
        sda_rel = b;
        hold();
        scl = 1'b1;
        hold();
        r = sda_line;
        scl = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // start or repeated start: sda falls with scl high
    task automatic start();
        sda_rel = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sda_rel = 1'b0;
        hold();
        scl = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // stop: sda rises with scl high
    task automatic stop();
        sda_rel = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_rel = 1'b1;
        hold();
    endtask
    // byte out msb first, then the slave ack bit
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // byte in msb first; host then acks when ack is high, nacks when it is low
    task automatic recv(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule
`default_nettype wire

// File: verif/sensor_user_config_register_checker.sv
// port assertions for the user configuration slave
`timescale 1ns/1ps
`default_nettype none
`include "ucfg_params.svh"
module sensor_user_config_checker #(
    parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // serial bus and supply monitor input
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire logic SUPPLY_LOW_IN,
    // decoded configuration
    input wire logic HEATER_ENABLE,
    input wire logic [1:0] RESOLUTION_CODE,
    input wire logic [4:0] HUMIDITY_BITS,
    input wire logic [4:0] TEMPERATURE_BITS
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // widths for a resolution code
    function automatic logic [9:0] width_of(input logic [1:0] c);
        case (c)
            2'h0: return {`UCFG_RH_BITS_00, `UCFG_T_BITS_00};
            2'h1: return {`UCFG_RH_BITS_01, `UCFG_T_BITS_01};
            2'h2: return {`UCFG_RH_BITS_10, `UCFG_T_BITS_10};
            default: return {`UCFG_RH_BITS_11, `UCFG_T_BITS_11};
        endcase
    endfunction
    // a stored change finds the ack of its data byte already driven, from one cycle before
    sequence ack_soon;
        1'b1 ##[0:8] SDA_OE;
    endsequence
    a_drive_low: assert property (SDA_OUT == 1'b0)
        else $error("sda output value not low");
    a_width_follow: assert property (
        {HUMIDITY_BITS, TEMPERATURE_BITS} == width_of(RESOLUTION_CODE))
        else $error("widths do not match resolution code");
    a_reset_state: assert property ($rose(RST_N) |->
        !HEATER_ENABLE && RESOLUTION_CODE == 2'h0 && !SDA_OE)
        else $error("wrong state after reset");
    a_heater_cause: assert property ($changed(HEATER_ENABLE) |-> ack_soon)
        else $error("heater changed without a write");
    a_code_cause: assert property ($changed(RESOLUTION_CODE) |-> ack_soon)
        else $error("resolution changed without a write");
    a_cfg_scl_low: assert property (
        $changed({HEATER_ENABLE, RESOLUTION_CODE}) |-> !SCL_IN)
        else $error("config changed while scl high");
    a_oe_scl_low: assert property ($changed(SDA_OE) |-> $past(SCL_IN, 2) == 1'b0)
        else $error("sda drive changed outside scl low");
    a_oe_stands: assert property ($changed(SDA_OE) |=> $stable(SDA_OE) [*3])
        else $error("sda drive did not hold");
    c_heater_on: cover property ($rose(HEATER_ENABLE));
endmodule
bind sensor_user_config_register sensor_user_config_checker #(.SLAVE_ADDR(SLAVE_ADDR)) i_chk (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SUPPLY_LOW_IN(SUPPLY_LOW_IN),
    .HEATER_ENABLE(HEATER_ENABLE), .RESOLUTION_CODE(RESOLUTION_CODE),
    .HUMIDITY_BITS(HUMIDITY_BITS), .TEMPERATURE_BITS(TEMPERATURE_BITS));
`default_nettype wire

// File: verif/sensor_user_config_register_tb_top.sv
// self-checking bench for the user configuration slave
`timescale 1ns/1ps
`default_nettype none
`include "ucfg_params.svh"
`define CHECK(got, exp, what) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp); \
        end \
    end
module sensor_user_config_register_tb_top;
    localparam logic [6:0] ADDR = 7'h45; // arbitrary bus address
    logic ref_clk;
    logic rst_n = 1'b0;
    logic supply_low = 1'b0;
    logic scl, sda_rel, sda_out, sda_oe, heater, ack;
    logic [1:0] res_code;
    logic [4:0] rh_bits, t_bits;
    logic [7:0] rd, val;
    logic [31:0] rnd;
    int err_total = 0;
    int checks = 0;
    int seed = 18697;
    // open-drain line with pull-up
    wire logic sda_line = sda_rel & (sda_oe ? sda_out : 1'b1);
    sensor_user_config_register #(.SLAVE_ADDR(ADDR)) i_sensor_user_config_register (
        .REF_CLK(ref_clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda_line),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SUPPLY_LOW_IN(supply_low),
        .HEATER_ENABLE(heater), .RESOLUTION_CODE(res_code),
        .HUMIDITY_BITS(rh_bits), .TEMPERATURE_BITS(t_bits));
    i2c_host_model i_i2c_host_model (.clk(ref_clk), .scl(scl), .sda_rel(sda_rel),
        .sda_line(sda_line));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // read value expected after data v was stored
    function automatic logic [7:0] exp_read(input logic [7:0] v, input logic s);
        return {v[7], s, 3'b111, v[2], 1'b1, v[0]};
    endfunction
    // conversion widths {humidity, temperature} for a resolution code
    function automatic logic [9:0] exp_widths(input logic [1:0] c);
        case (c)
            2'h0: return {`UCFG_RH_BITS_00, `UCFG_T_BITS_00};
            2'h1: return {`UCFG_RH_BITS_01, `UCFG_T_BITS_01};
            2'h2: return {`UCFG_RH_BITS_10, `UCFG_T_BITS_10};
            default: return {`UCFG_RH_BITS_11, `UCFG_T_BITS_11};
        endcase
    endfunction
    // command, then one data byte; address ack expected, command and data acks as given
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input logic exp_ack);
        i_i2c_host_model.start();
        i_i2c_host_model.send({ADDR, 1'b0}, ack);
        `CHECK(ack, 1'b1, "address ack");
        i_i2c_host_model.send(cmd, ack);
        `CHECK(ack, exp_ack, "command ack");
        i_i2c_host_model.send(d, ack);
        `CHECK(ack, exp_ack, "data ack");
        i_i2c_host_model.stop();
    endtask
    // register read; a host ack pulls one more byte that must be idle line
    task automatic rdreg(input logic host_ack, output logic [7:0] d);
        logic [7:0] extra;
        i_i2c_host_model.start();
        i_i2c_host_model.send({ADDR, 1'b0}, ack);
        i_i2c_host_model.send(`UCFG_CMD_READ, ack);
        `CHECK(ack, 1'b1, "read command ack");
        i_i2c_host_model.start();
        i_i2c_host_model.send({ADDR, 1'b1}, ack);
        `CHECK(ack, 1'b1, "read address ack");
        i_i2c_host_model.recv(host_ack, d);
        if (host_ack) begin
            i_i2c_host_model.recv(1'b0, extra);
            `CHECK(extra, 8'hff, "byte after data");
        end
        i_i2c_host_model.stop();
    endtask
    // read back and compare with the stored data v
    task automatic check_cfg(input logic [7:0] v, input logic host_ack);
        rdreg(host_ack, rd);
        `CHECK(rd, exp_read(v, supply_low), "read value");
        `CHECK(heater, v[2], "heater");
        `CHECK(res_code, {v[7], v[0]}, "resolution");
        `CHECK({rh_bits, t_bits}, exp_widths({v[7], v[0]}), "widths");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // main sequence; besides the user register, the reserved command 8'he5 and a foreign address are tried
    initial begin
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        check_cfg(`UCFG_RESET_VALUE, 1'b0);
        $display("test reset value done");
        for (int i = 0; i < 12; i++) begin
            rnd = $random(seed);
            // corners write every code with reserved and flag bits flipped
            val = {i[1], 1'b1, 3'b000, i[0], 1'b0, i[0]};
            if (i >= 4) begin
                val = (rnd[7:0] & ~`UCFG_RESERVED_MASK) | (rd & `UCFG_RESERVED_MASK);
                supply_low = rnd[8];
            end
            wr(`UCFG_CMD_WRITE, val, 1'b1);
            check_cfg(val, i == 11);
        end
        $display("test write and read done");
        i_i2c_host_model.half = 20;
        wr(8'he5, ~val, 1'b0);
        // read address with no pending read command, then a foreign address
        i_i2c_host_model.start();
        i_i2c_host_model.send({ADDR, 1'b1}, ack);
        `CHECK(ack, 1'b0, "bare read address");
        i_i2c_host_model.stop();
        i_i2c_host_model.start();
        i_i2c_host_model.send({ADDR ^ 7'h01, 1'b0}, ack);
        `CHECK(ack, 1'b0, "foreign address");
        i_i2c_host_model.stop();
        check_cfg(val, 1'b0);
        $display("test refused command done");
        rst_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        supply_low = 1'b0;
        check_cfg(`UCFG_RESET_VALUE, 1'b0);
        $display("test second reset done");
        results();
    end
    // watchdog sized well beyond the expected run
    initial begin
        repeat (80000) @(posedge ref_clk);
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end
endmodule
`default_nettype wire
